// >>> rtl/usbde_defs.svh
`ifndef USBDE_DEFS_SVH
`define USBDE_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define USBDE_ADDR_STATUS 8'h00
`define USBDE_ADDR_MASK 8'h04
`define USBDE_ADDR_CONFIG 8'h08
`define USBDE_ADDR_COMMAND 8'h0c
`define USBDE_ADDR_TXDESC 8'h10
`define USBDE_ADDR_TXRESULT 8'h14
`define USBDE_ADDR_RXFREE 8'h18
`define USBDE_ADDR_STATE 8'h1c

// ****************************************
// status and mask bit positions
// ****************************************
`define USBDE_EV_TX_DONE 0
`define USBDE_EV_TIMEOUT 1
`define USBDE_EV_NAK 2
`define USBDE_EV_OVERFLOW 3
`define USBDE_EV_FLUSH 4
`define USBDE_EV_W 5

// ****************************************
// config fields
// ****************************************
`define USBDE_CFG_MULTI 0
`define USBDE_CFG_NAK 1
`define USBDE_CFG_RESET 2'h0

// ****************************************
// transmit descriptor fields
// ****************************************
`define USBDE_TXD_READY 0
`define USBDE_TXD_CONFIRM 1
`define USBDE_TXD_TIMEOUT 2
`define USBDE_TXD_IN 3
`define USBDE_TXD_PKTS_LSB 8
`define USBDE_TXD_PKTS_MSB 11

// ****************************************
// command codes
// ****************************************
`define USBDE_CMD_FLUSH 8'h01
`define USBDE_CMD_HALT 8'h02
`define USBDE_CMD_RESUME 8'h03

// ****************************************
// timing
// ****************************************
`define USBDE_CLK_MHZ 250
`define USBDE_BIT_NS 84
`define USBDE_BIT_CYC ((`USBDE_BIT_NS * `USBDE_CLK_MHZ + 999) / 1000)
`define USBDE_TURN_BITS 16
`define USBDE_TURN_CYC (`USBDE_TURN_BITS * `USBDE_BIT_CYC)
`define USBDE_RXDESC_MAX 4'h8

`endif

// >>> rtl/usbde_pkg.sv
package usbde_pkg;
    typedef enum logic [1:0] {
        USBDE_IDLE = 2'b00,
        USBDE_SEND = 2'b01,
        USBDE_WAIT = 2'b11,
        USBDE_CLOSE = 2'b10
    } usbde_tx_state_type;
endpackage : usbde_pkg

// >>> rtl/usbde_engine.sv
`timescale 1ns/100ps
`include "usbde_defs.svh"

module usbde_engine (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic O_IRQ,
    output logic O_PKT_START,
    output logic O_HANDSHAKE_NAK,
    output logic O_HANDSHAKE_ACK,
    output logic O_RX_STORE,
    input wire logic I_PKT_SENT,
    input wire logic I_PID_VALID,
    input wire logic I_STUFF_ERR,
    input wire logic I_OUT_RECEIVED,
    input wire logic I_RX_DESC_RETURN
);

    // ****************************************
    // state
    // ****************************************
    logic [`USBDE_EV_W-1:0] status_reg, status_next;
    logic [`USBDE_EV_W-1:0] mask_reg, mask_next;
    logic [1:0] config_reg, config_next;
    logic [15:0] txdesc_reg, txdesc_next;
    logic [15:0] txresult_reg, txresult_next;
    logic [3:0] rxfree_reg, rxfree_next;
    logic halted_reg, halted_next;
    logic overflow_reg, overflow_next;
    logic [3:0] pkts_left_reg, pkts_left_next;
    logic [9:0] timer_reg, timer_next;
    usbde_pkg::usbde_tx_state_type state_reg, state_next;
    logic [31:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic start_reg, start_next;
    logic nak_reg, nak_next;
    logic ack_reg, ack_next;
    logic store_reg, store_next;
    logic [`USBDE_EV_W-1:0] ev_bus, ev_rx, ev_tx, ev_all;
    logic wr_cmd, cmd_flush, cmd_halt, cmd_resume;
    logic tx_idle, single_pkt;
    logic [3:0] pkt_count;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ****************************************
    // counter step
    // ****************************************
    function automatic logic [3:0] step(input logic [3:0] v, input logic up);
        if (up) begin
            step = v + 4'h1;
        end else begin
            step = v - 4'h1;
        end
    endfunction : step

    // ****************************************
    // command decode
    // ****************************************
    always_comb begin
        wr_cmd = I_WR && hit(I_ADDR, `USBDE_ADDR_COMMAND);
        cmd_flush = wr_cmd && hit(I_WDATA[7:0], `USBDE_CMD_FLUSH);
        cmd_halt = wr_cmd && hit(I_WDATA[7:0], `USBDE_CMD_HALT);
        cmd_resume = wr_cmd && hit(I_WDATA[7:0], `USBDE_CMD_RESUME);
        tx_idle = (state_reg == usbde_pkg::USBDE_IDLE);
        single_pkt = !config_reg[`USBDE_CFG_MULTI]
            || txdesc_reg[`USBDE_TXD_CONFIRM];
        pkt_count = txdesc_reg[`USBDE_TXD_PKTS_MSB:`USBDE_TXD_PKTS_LSB];
        if (pkt_count == 4'h0) begin
            pkt_count = 4'h1;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_comb begin
        ev_bus = '0;
        mask_next = mask_reg;
        config_next = config_reg;
        halted_next = halted_reg;
        if (I_WR && hit(I_ADDR, `USBDE_ADDR_MASK)) begin
            mask_next = I_WDATA[`USBDE_EV_W-1:0];
        end
        if (I_WR && hit(I_ADDR, `USBDE_ADDR_CONFIG)) begin
            config_next = I_WDATA[1:0];
        end
        if (cmd_halt) begin
            halted_next = 1'b1;
        end
        if (cmd_resume) begin
            halted_next = 1'b0;
        end
        ev_bus[`USBDE_EV_FLUSH] = cmd_flush;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mask_reg <= '0;
            config_reg <= `USBDE_CFG_RESET;
            halted_reg <= 1'b0;
        end else begin
            mask_reg <= mask_next;
            config_reg <= config_next;
            halted_reg <= halted_next;
        end
    end

    // ****************************************
    // receive side
    // ****************************************
    always_comb begin
        ev_rx = '0;
        rxfree_next = rxfree_reg;
        overflow_next = overflow_reg;
        nak_next = 1'b0;
        ack_next = 1'b0;
        store_next = 1'b0;
        if (cmd_flush) begin
            overflow_next = 1'b0;
        end
        if (I_RX_DESC_RETURN && rxfree_reg != `USBDE_RXDESC_MAX) begin
            rxfree_next = step(rxfree_reg, 1'b1);
            overflow_next = 1'b0;
        end
        if (I_OUT_RECEIVED) begin
            if (config_reg[`USBDE_CFG_NAK]) begin
                nak_next = 1'b1;
                ev_rx[`USBDE_EV_NAK] = 1'b1;
            end else if (rxfree_reg == 4'h0) begin
                overflow_next = 1'b1;
                ev_rx[`USBDE_EV_OVERFLOW] = 1'b1;
            end else begin
                store_next = 1'b1;
                ack_next = 1'b1;
                rxfree_next = step(rxfree_next, 1'b0);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rxfree_reg <= `USBDE_RXDESC_MAX;
            overflow_reg <= 1'b0;
            nak_reg <= 1'b0;
            ack_reg <= 1'b0;
            store_reg <= 1'b0;
        end else begin
            rxfree_reg <= rxfree_next;
            overflow_reg <= overflow_next;
            nak_reg <= nak_next;
            ack_reg <= ack_next;
            store_reg <= store_next;
        end
    end

    // ****************************************
    // transmit side
    // ****************************************
    always_comb begin
        ev_tx = '0;
        txdesc_next = txdesc_reg;
        txresult_next = txresult_reg;
        pkts_left_next = pkts_left_reg;
        timer_next = timer_reg;
        state_next = state_reg;
        start_next = 1'b0;
        if (I_WR && hit(I_ADDR, `USBDE_ADDR_TXDESC) && tx_idle) begin
            txdesc_next = I_WDATA[15:0];
        end
        case (state_reg)
            usbde_pkg::USBDE_IDLE: begin
                if (txdesc_reg[`USBDE_TXD_READY] && !halted_reg) begin
                    pkts_left_next = single_pkt ? 4'h1 : pkt_count;
                    start_next = 1'b1;
                    state_next = usbde_pkg::USBDE_SEND;
                end
            end
            usbde_pkg::USBDE_SEND: begin
                if (I_PKT_SENT) begin
                    timer_next = 10'h0;
                    state_next = usbde_pkg::USBDE_WAIT;
                end
            end
            usbde_pkg::USBDE_WAIT: begin
                timer_next = timer_reg + 10'h1;
                if (I_STUFF_ERR) begin
                    txdesc_next[`USBDE_TXD_TIMEOUT] = 1'b1;
                    state_next = usbde_pkg::USBDE_CLOSE;
                end else if (I_PID_VALID) begin
                    if (pkts_left_reg > 4'h1 && !halted_reg) begin
                        pkts_left_next = step(pkts_left_reg, 1'b0);
                        start_next = 1'b1;
                        state_next = usbde_pkg::USBDE_SEND;
                    end else begin
                        state_next = usbde_pkg::USBDE_CLOSE;
                    end
                end else if (timer_reg >= 10'(`USBDE_TURN_CYC - 1)) begin
                    txdesc_next[`USBDE_TXD_TIMEOUT] = 1'b1;
                    state_next = usbde_pkg::USBDE_CLOSE;
                end
            end
            usbde_pkg::USBDE_CLOSE: begin
                txdesc_next[`USBDE_TXD_READY] = 1'b0;
                txresult_next = txdesc_next;
                ev_tx[`USBDE_EV_TX_DONE] = 1'b1;
                ev_tx[`USBDE_EV_TIMEOUT] = txdesc_reg[`USBDE_TXD_TIMEOUT];
                state_next = usbde_pkg::USBDE_IDLE;
            end
            default: state_next = usbde_pkg::USBDE_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            txdesc_reg <= 16'h0;
            txresult_reg <= 16'h0;
            pkts_left_reg <= 4'h0;
            timer_reg <= 10'h0;
            state_reg <= usbde_pkg::USBDE_IDLE;
            start_reg <= 1'b0;
        end else begin
            txdesc_reg <= txdesc_next;
            txresult_reg <= txresult_next;
            pkts_left_reg <= pkts_left_next;
            timer_reg <= timer_next;
            state_reg <= state_next;
            start_reg <= start_next;
        end
    end

    // ****************************************
    // status and interrupt
    // ****************************************
    always_comb begin
        ev_all = ev_bus | ev_rx | ev_tx;
        status_next = status_reg;
        if (I_RD && hit(I_ADDR, `USBDE_ADDR_STATUS)) begin
            status_next = '0;
        end
        // a new event wins over the read clear
        status_next = status_next | ev_all;
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= irq_next;
        end
    end

    // ****************************************
    // readback
    // ****************************************
    always_comb begin
        rdata_next = 32'h0;
        if (I_RD) begin
            case (I_ADDR)
                `USBDE_ADDR_STATUS: rdata_next = {27'h0, status_reg};
                `USBDE_ADDR_MASK: rdata_next = {27'h0, mask_reg};
                `USBDE_ADDR_CONFIG: rdata_next = {30'h0, config_reg};
                `USBDE_ADDR_TXDESC: rdata_next = {16'h0, txdesc_reg};
                `USBDE_ADDR_TXRESULT: rdata_next = {16'h0, txresult_reg};
                `USBDE_ADDR_RXFREE: rdata_next = {28'h0, rxfree_reg};
                `USBDE_ADDR_STATE: rdata_next = {26'h0, pkts_left_reg,
                    halted_reg, overflow_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_IRQ = irq_reg;
    assign O_PKT_START = start_reg;
    assign O_HANDSHAKE_NAK = nak_reg;
    assign O_HANDSHAKE_ACK = ack_reg;
    assign O_RX_STORE = store_reg;

endmodule : usbde_engine

// >>> tb/usbde_engine_chk.sv
`timescale 1ns/100ps
// ****
// port checker
// ****
module usbde_engine_chk (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic O_PKT_START,
    input wire logic O_HANDSHAKE_NAK,
    input wire logic O_HANDSHAKE_ACK,
    input wire logic O_RX_STORE,
    input wire logic I_PKT_SENT,
    input wire logic I_OUT_RECEIVED
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);
    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data outside answer cycle");
    ack_store_a: assert property (O_HANDSHAKE_ACK |-> O_RX_STORE)
        else $error("ack without store");
    nak_drop_a: assert property (O_HANDSHAKE_NAK |-> !O_RX_STORE)
        else $error("nak stored data");
    nak_cause_a: assert property (O_HANDSHAKE_NAK |-> $past(I_OUT_RECEIVED))
        else $error("nak without out packet");
    store_cause_a: assert property (O_RX_STORE |-> $past(I_OUT_RECEIVED))
        else $error("store without out packet");
    hs_excl_a: assert property (I_OUT_RECEIVED |=>
        !(O_HANDSHAKE_ACK && O_HANDSHAKE_NAK))
        else $error("ack and nak together");
    one_pkt_a: assert property (O_PKT_START |=> (!O_PKT_START)[*8])
        else $error("packets started too close");
    send_quiet_a: assert property (I_PKT_SENT |-> !O_PKT_START)
        else $error("start while sending");
endmodule : usbde_engine_chk

// >>> tb/usbde_link_model.sv
`timescale 1ns/100ps
// ****
// usb far side: answers each packet with a valid pid in mode 0, a stuff error in mode 1, nothing in modes 2 and 3
// ****
module usbde_link_model (
    input wire logic i_clk,
    input wire logic i_pkt_start,
    input wire logic [1:0] i_mode,
    output logic o_pkt_sent,
    output logic o_pid_valid,
    output logic o_stuff_err
);
    initial begin
        o_pkt_sent = 1'b0;
        o_pid_valid = 1'b0;
        o_stuff_err = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_pkt_start) begin
                repeat (5) @(posedge i_clk);
                o_pkt_sent <= 1'b1;
                @(posedge i_clk);
                o_pkt_sent <= 1'b0;
                repeat (9) @(posedge i_clk);
                o_pid_valid <= (i_mode == 2'h0);
                o_stuff_err <= (i_mode == 2'h1);
                @(posedge i_clk);
                o_pid_valid <= 1'b0;
                o_stuff_err <= 1'b0;
            end
        end
    end
endmodule : usbde_link_model

// >>> tb/tb_usbde_engine.sv
`timescale 1ns/100ps
`include "usbde_defs.svh"
module tb_usbde_engine;
    logic clk = 0, arst_n = 0, wr = 0, rd = 0, out_rx = 0, ret = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, q;
    logic [1:0] mode = 2'h0;
    wire [31:0] rdata;
    wire irq, pst, nak, ack, sto, sent, pidv, serr;
    int n_errors = 0, tests_run = 0, n_st = 0, n_ack = 0, n_nak = 0, n_sto = 0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        n_st += pst;
        n_ack += ack;
        n_nak += nak;
        n_sto += sto;
    end
    usbde_engine DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_IRQ(irq), .O_PKT_START(pst), .O_HANDSHAKE_NAK(nak),
        .O_HANDSHAKE_ACK(ack), .O_RX_STORE(sto), .I_PKT_SENT(sent),
        .I_PID_VALID(pidv), .I_STUFF_ERR(serr), .I_OUT_RECEIVED(out_rx),
        .I_RX_DESC_RETURN(ret));
    usbde_link_model LNK (.i_clk(clk), .i_pkt_start(pst), .i_mode(mode),
        .o_pkt_sent(sent), .o_pid_valid(pidv), .o_stuff_err(serr));
    // ****
    // bus tasks
    // ****
    task wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32
    task rd32(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd32
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task rchk(input string n, input logic [7:0] a, input logic [31:0] m, e);
        rd32(a, q);
        chk(n, e, q & m);
    endtask : rchk
    task pulse_out;
        @(posedge clk);
        out_rx <= 1'b1;
        @(posedge clk);
        out_rx <= 1'b0;
        @(posedge clk);
        #1;
    endtask : pulse_out
    task wait_irq;
        int i;
        for (i = 0; i < 900 && irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("irq", 32'h1, {31'h0, irq});
    endtask : wait_irq
    task tx(input logic [31:0] d, input logic [1:0] m,
        input logic [31:0] r, s);
        mode <= m;
        wr32(`USBDE_ADDR_TXDESC, d);
        wait_irq();
        rchk("txresult", `USBDE_ADDR_TXRESULT, 32'h5, r);
        rchk("status", `USBDE_ADDR_STATUS, 32'h1f, s);
    endtask : tx
    task final_report;
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
    // ****
    // tests
    // ****
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rchk("rxfree", `USBDE_ADDR_RXFREE, 32'hffffffff, 32'h8);
        rchk("config", `USBDE_ADDR_CONFIG, 32'hffffffff, 32'h0);
        rchk("unmapped", 8'hfc, 32'hffffffff, 32'h0);
        wr32(`USBDE_ADDR_MASK, 32'h1f);
        tx(32'h103, 2'h0, 32'h0, 32'h1);
        tx(32'h103, 2'h1, 32'h4, 32'h3);
        tx(32'h10b, 2'h1, 32'h4, 32'h3);
        tx(32'h103, 2'h2, 32'h4, 32'h3);
        wr32(`USBDE_ADDR_CONFIG, 32'h1);
        n_st = 0;
        tx(32'h301, 2'h0, 32'h0, 32'h1);
        chk("starts", 32'h3, n_st);
        n_st = 0;
        tx(32'h303, 2'h0, 32'h0, 32'h1);
        chk("starts", 32'h1, n_st);
        wr32(`USBDE_ADDR_CONFIG, 32'h0);
        n_st = 0;
        wr32(`USBDE_ADDR_COMMAND, `USBDE_CMD_HALT);
        wr32(`USBDE_ADDR_TXDESC, 32'h103);
        repeat (100) @(posedge clk);
        chk("halted", 32'h0, n_st);
        rchk("state", `USBDE_ADDR_STATE, 32'h2, 32'h2);
        wr32(`USBDE_ADDR_COMMAND, `USBDE_CMD_FLUSH);
        repeat (63) @(posedge clk);
        wr32(`USBDE_ADDR_COMMAND, `USBDE_CMD_FLUSH);
        rchk("status", `USBDE_ADDR_STATUS, 32'h1f, 32'h10);
        wr32(`USBDE_ADDR_COMMAND, `USBDE_CMD_RESUME);
        wait_irq();
        chk("starts", 32'h1, n_st);
        rchk("status", `USBDE_ADDR_STATUS, 32'h1f, 32'h1);
        repeat (8) pulse_out();
        rchk("rxfree", `USBDE_ADDR_RXFREE, 32'hf, 32'h0);
        pulse_out();
        chk("stores", 32'h8, n_sto);
        chk("acks", 32'h8, n_ack);
        rchk("state", `USBDE_ADDR_STATE, 32'h1, 32'h1);
        rchk("status", `USBDE_ADDR_STATUS, 32'h1f, 32'h8);
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        rchk("rxfree", `USBDE_ADDR_RXFREE, 32'hf, 32'h1);
        wr32(`USBDE_ADDR_COMMAND, `USBDE_CMD_FLUSH);
        rchk("state", `USBDE_ADDR_STATE, 32'h1, 32'h0);
        rchk("status", `USBDE_ADDR_STATUS, 32'h10, 32'h10);
        wr32(`USBDE_ADDR_CONFIG, 32'h2);
        pulse_out();
        chk("naks", 32'h1, n_nak);
        chk("stores", 32'h8, n_sto);
        rchk("status", `USBDE_ADDR_STATUS, 32'h1f, 32'h4);
        wr32(`USBDE_ADDR_CONFIG, 32'h0);
        pulse_out();
        chk("stores", 32'h9, n_sto);
        wr32(`USBDE_ADDR_MASK, 32'h0);
        pulse_out();
        repeat (2) @(posedge clk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr32(`USBDE_ADDR_MASK, 32'h8);
        #1 chk("irq", 32'h1, {31'h0, irq});
        rd32(`USBDE_ADDR_STATUS, q);
        chk("irq", 32'h0, {31'h0, irq});
        final_report();
    end
endmodule : tb_usbde_engine
bind usbde_engine usbde_engine_chk CHK (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .O_PKT_START(O_PKT_START),
    .O_HANDSHAKE_NAK(O_HANDSHAKE_NAK), .O_HANDSHAKE_ACK(O_HANDSHAKE_ACK),
    .O_RX_STORE(O_RX_STORE), .I_PKT_SENT(I_PKT_SENT),
    .I_OUT_RECEIVED(I_OUT_RECEIVED));
